// file: rtl/ciu_cfg.svh
`ifndef CIU_CFG_SVH
`define CIU_CFG_SVH
// register offsets on the control port
`define CIU_OFS_CONFIG 8'h1E
`define CIU_OFS_MASK_PRI 8'h1F
`define CIU_OFS_MASK_CLIP 8'h20
`define CIU_OFS_FLAGS_PRI 8'h21
`define CIU_OFS_FLAGS_CLIP 8'h22
// field positions
`define CIU_BIT_AUTOMASK 7
`define CIU_STYLE_HI 6
`define CIU_STYLE_LO 5
`define CIU_BIT_TEST 7
`define CIU_BIT_SERIAL 6
`define CIU_BIT_CLOCK 5
`define CIU_IN_HI 3
`define CIU_OUT_HI 4
// reset values
`define CIU_CONFIG_RST 8'h00
`define CIU_MASK_RST 8'h00
`define CIU_BYTE_ZERO 8'h00
// writable bits of the config and mask registers
`define CIU_CONFIG_WMASK 8'hE0
`define CIU_MASK_PRI_WMASK 8'hEF
`define CIU_MASK_CLIP_WMASK 8'h1F
`endif

// file: rtl/ciu_pkg.sv
package ciu_pkg;
    // interrupt pin output style
    typedef enum logic [1:0] {
        CIU_STYLE_HIGH = 2'b00,
        CIU_STYLE_LOW = 2'b01,
        CIU_STYLE_OD = 2'b10,
        CIU_STYLE_RSVD = 2'b11
    } ciu_style_t;
endpackage

// file: rtl/ciu_pin_drive.sv
`timescale 1ns/10ps
`include "ciu_cfg.svh"
// drives the interrupt pin in the chosen output style
module ciu_pin_drive
    import ciu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic irq_active,
    input wire logic [1:0] style,
    output logic irq_pin_o,
    output logic irq_pin_oe
);
    logic out_reg;
    logic oe_reg;
    logic out_next;
    logic oe_next;
    ciu_style_t style_sel;

    assign style_sel = ciu_style_t'(style);

    // style decode; reserved code treated as active high
    always_comb
    begin
        out_next = irq_active;
        oe_next = 1'b1;
        unique case (style_sel)
            CIU_STYLE_HIGH:
            begin
                out_next = irq_active;
                oe_next = 1'b1;
            end
            CIU_STYLE_LOW:
            begin
                out_next = ~irq_active;
                oe_next = 1'b1;
            end
            CIU_STYLE_OD:
            begin
                out_next = 1'b0;
                oe_next = irq_active;
            end
            CIU_STYLE_RSVD:
            begin
                out_next = irq_active;
                oe_next = 1'b1;
            end
        endcase
    end

    // registered pin drive
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_reg <= 1'b0;
            oe_reg <= 1'b1;
        end
        else
        begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign irq_pin_o = out_reg;
    assign irq_pin_oe = oe_reg;

    AST_OD_NEVER_HIGH:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            $past(style_sel) == CIU_STYLE_OD |-> !(irq_pin_oe && irq_pin_o))
        else $error("open drain pin driven high");
endmodule

// file: rtl/ciu_core.sv
`timescale 1ns/10ps
`include "ciu_cfg.svh"
module ciu_core
    import ciu_pkg::*;
#(
    parameter int N_IN = 4,
    parameter int N_OUT = 5
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic test_mode_entry,
    input wire logic [1:0] serial_frame_format,
    input wire logic [1:0] rate_class,
    input wire logic clock_ratio_change,
    input wire logic [N_IN-1:0] adc_pdn,
    input wire logic [N_OUT-1:0] dac_pdn,
    input wire logic [N_IN-1:0] input_overrange,
    input wire logic [N_OUT-1:0] output_saturation,
    output logic irq_pin_o,
    output logic irq_pin_oe
);
    logic [7:0] config_reg;
    logic [7:0] config_next;
    logic [7:0] mask_pri_reg;
    logic [7:0] mask_pri_next;
    logic [7:0] mask_clip_reg;
    logic [7:0] mask_clip_next;
    logic [7:0] flags_pri_reg;
    logic [7:0] flags_pri_next;
    logic [7:0] flags_clip_reg;
    logic [7:0] flags_clip_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] fmt_reg;
    logic [1:0] rate_reg;
    logic [7:0] ev_pri;
    logic [7:0] ev_clip;
    logic [7:0] clr_pri;
    logic [7:0] clr_clip;
    logic [7:0] auto_pri;
    logic [7:0] auto_clip;
    logic full_pdn;
    logic setting_change;
    logic serial_ev;
    logic automask_off;
    logic irq_active;
    logic rd_flags_pri;
    logic rd_flags_clip;

    // address match, used for reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign rd_flags_pri = reg_rd && hit(reg_addr, `CIU_OFS_FLAGS_PRI);
    assign rd_flags_clip = reg_rd && hit(reg_addr, `CIU_OFS_FLAGS_CLIP);
    assign automask_off = config_reg[`CIU_BIT_AUTOMASK];

    // fault detection on converter power state
    assign full_pdn = (&adc_pdn) && (&dac_pdn);
    assign setting_change = (serial_frame_format != fmt_reg) ||
        (rate_class != rate_reg);
    assign serial_ev = !full_pdn && (setting_change ||
        clock_ratio_change);

    // event vectors in flag layout
    always_comb
    begin
        ev_pri = `CIU_BYTE_ZERO;
        ev_pri[`CIU_BIT_TEST] = test_mode_entry;
        ev_pri[`CIU_BIT_SERIAL] = serial_ev;
        ev_pri[`CIU_BIT_CLOCK] = !full_pdn && clock_ratio_change;
        ev_pri[`CIU_IN_HI:0] = input_overrange;
        ev_clip = `CIU_BYTE_ZERO;
        ev_clip[`CIU_OUT_HI:0] = output_saturation;
    end

    // read clears flags; a same-cycle event still sets
    assign clr_pri = rd_flags_pri ? flags_pri_reg : `CIU_BYTE_ZERO;
    assign clr_clip = rd_flags_clip ? flags_clip_reg : `CIU_BYTE_ZERO;
    assign flags_pri_next = (flags_pri_reg & ~clr_pri) | ev_pri;
    assign flags_clip_next = (flags_clip_reg & ~clr_clip) | ev_clip;

    // automask: flags returned by a read set their mask bits
    assign auto_pri = automask_off ? `CIU_BYTE_ZERO : clr_pri;
    assign auto_clip = automask_off ? `CIU_BYTE_ZERO : clr_clip;

    // register writes and automask update
    always_comb
    begin
        config_next = config_reg;
        mask_pri_next = mask_pri_reg | auto_pri;
        mask_clip_next = mask_clip_reg | auto_clip;
        if (reg_wr && hit(reg_addr, `CIU_OFS_CONFIG))
            config_next = reg_wdata & `CIU_CONFIG_WMASK;
        if (reg_wr && hit(reg_addr, `CIU_OFS_MASK_PRI))
            mask_pri_next = (reg_wdata & `CIU_MASK_PRI_WMASK) | auto_pri;
        if (reg_wr && hit(reg_addr, `CIU_OFS_MASK_CLIP))
            mask_clip_next = (reg_wdata & `CIU_MASK_CLIP_WMASK) | auto_clip;
    end

    // read data mux; unmapped reads return zero
    always_comb
    begin
        rdata_next = rdata_reg;
        if (reg_rd)
        begin
            rdata_next = `CIU_BYTE_ZERO;
            if (hit(reg_addr, `CIU_OFS_CONFIG))
                rdata_next = config_reg;
            if (hit(reg_addr, `CIU_OFS_MASK_PRI))
                rdata_next = mask_pri_reg;
            if (hit(reg_addr, `CIU_OFS_MASK_CLIP))
                rdata_next = mask_clip_reg;
            if (hit(reg_addr, `CIU_OFS_FLAGS_PRI))
                rdata_next = flags_pri_reg;
            if (hit(reg_addr, `CIU_OFS_FLAGS_CLIP))
                rdata_next = flags_clip_reg;
        end
    end

    // unmasked latched flags drive the pin
    assign irq_active = |(flags_pri_reg & ~mask_pri_reg) ||
        |(flags_clip_reg & ~mask_clip_reg);

    // state registers
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            config_reg <= `CIU_CONFIG_RST;
            mask_pri_reg <= `CIU_MASK_RST;
            mask_clip_reg <= `CIU_MASK_RST;
            flags_pri_reg <= `CIU_BYTE_ZERO;
            flags_clip_reg <= `CIU_BYTE_ZERO;
            rdata_reg <= `CIU_BYTE_ZERO;
            fmt_reg <= 2'h0;
            rate_reg <= 2'h0;
        end
        else
        begin
            config_reg <= config_next;
            mask_pri_reg <= mask_pri_next;
            mask_clip_reg <= mask_clip_next;
            flags_pri_reg <= flags_pri_next;
            flags_clip_reg <= flags_clip_next;
            rdata_reg <= rdata_next;
            fmt_reg <= serial_frame_format;
            rate_reg <= rate_class;
        end
    end

    assign reg_rdata = rdata_reg;

    ciu_pin_drive ciu_pin_drive_inst
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .irq_active(irq_active),
        .style(config_reg[`CIU_STYLE_HI:`CIU_STYLE_LO]),
        .irq_pin_o(irq_pin_o),
        .irq_pin_oe(irq_pin_oe)
    );

    AST_AUTOMASK_SET:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            rd_flags_pri && !automask_off && !reg_wr
            |=> ((mask_pri_reg & $past(flags_pri_reg)) ==
                $past(flags_pri_reg)))
        else $error("automask did not set mask bits");

    AST_NO_AUTOMASK:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            automask_off && !reg_wr |=> $stable(mask_pri_reg)
                && $stable(mask_clip_reg))
        else $error("mask changed without a write");

    AST_TEST_LATCH:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            test_mode_entry |=> flags_pri_reg[`CIU_BIT_TEST])
        else $error("test entry fault not latched");

    AST_SERIAL_LATCH:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            !full_pdn && setting_change |=> flags_pri_reg[`CIU_BIT_SERIAL])
        else $error("serial format fault not latched");

    AST_RATIO_BOTH:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            !full_pdn && clock_ratio_change |=>
                flags_pri_reg[`CIU_BIT_SERIAL] && flags_pri_reg[`CIU_BIT_CLOCK])
        else $error("ratio change did not set both faults");

    AST_PDN_QUIET:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            full_pdn && !rd_flags_pri |=> flags_pri_reg[`CIU_BIT_SERIAL]
                == $past(flags_pri_reg[`CIU_BIT_SERIAL]))
        else $error("serial fault set while powered down");

    AST_READ_CLEAR:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            rd_flags_clip && !(|output_saturation) |=> flags_clip_reg == 8'h00)
        else $error("clip flags not cleared by read");

    AST_PIN_ACTIVE:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            flags_pri_reg[`CIU_BIT_TEST] && !mask_pri_reg[`CIU_BIT_TEST]
            |=> irq_pin_oe && (irq_pin_o ==
                ($past(config_reg[`CIU_STYLE_HI]) ==
                $past(config_reg[`CIU_STYLE_LO]))))
        else $error("unmasked fault did not raise pin");

    AST_RESERVED_ZERO:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            mask_clip_reg[7:5] == 3'h0 && flags_pri_reg[4] == 1'b0)
        else $error("reserved bit set");

    // further checks on latching, clearing, masking and readback
    AST_AUTOMASK_CLIP:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            rd_flags_clip && !automask_off && !reg_wr
            |=> ((mask_clip_reg & $past(flags_clip_reg)) ==
                $past(flags_clip_reg)))
        else $error("automask did not set clip mask bits");

    AST_CLOCK_QUIET:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            full_pdn && !rd_flags_pri |=> flags_pri_reg[`CIU_BIT_CLOCK]
                == $past(flags_pri_reg[`CIU_BIT_CLOCK]))
        else $error("clock fault set while powered down");

    AST_PIN_IDLE:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            ((flags_pri_reg & ~mask_pri_reg) == `CIU_BYTE_ZERO) &&
            ((flags_clip_reg & ~mask_clip_reg) == `CIU_BYTE_ZERO) |=>
            (irq_pin_o == ($past(config_reg[`CIU_STYLE_LO]) &&
                !$past(config_reg[`CIU_STYLE_HI]))) &&
            (irq_pin_oe == !($past(config_reg[`CIU_STYLE_HI]) &&
                !$past(config_reg[`CIU_STYLE_LO]))))
        else $error("pin not idle with no unmasked flag");

    AST_OVR_LATCH:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            |input_overrange |=> (flags_pri_reg[`CIU_IN_HI:0] &
                $past(input_overrange)) == $past(input_overrange))
        else $error("input overrange not latched");

    AST_SAT_LATCH:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            |output_saturation |=> (flags_clip_reg[`CIU_OUT_HI:0] &
                $past(output_saturation)) == $past(output_saturation))
        else $error("output saturation not latched");

    AST_FLAGS_HOLD:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            !rd_flags_pri |=> (flags_pri_reg & $past(flags_pri_reg)) ==
                $past(flags_pri_reg))
        else $error("primary flag lost without a read");

    AST_CLIP_HOLD:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            !rd_flags_clip |=> (flags_clip_reg & $past(flags_clip_reg)) ==
                $past(flags_clip_reg))
        else $error("clip flag lost without a read");

    AST_FLAGS_READ:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            rd_flags_pri |=> reg_rdata == $past(flags_pri_reg))
        else $error("primary flags read back wrong");

    AST_RDATA_HOLD:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_MASK_WRITE:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            reg_wr && hit(reg_addr, `CIU_OFS_MASK_PRI) && automask_off
            |=> mask_pri_reg == ($past(reg_wdata) & `CIU_MASK_PRI_WMASK))
        else $error("primary mask write lost");

    AST_CLIP_WRITE:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            reg_wr && hit(reg_addr, `CIU_OFS_MASK_CLIP) && automask_off
            |=> mask_clip_reg == ($past(reg_wdata) & `CIU_MASK_CLIP_WMASK))
        else $error("clip mask write lost");

    AST_READ_CLEAR_PRI:
        assert property (@(posedge clk_sys) disable iff (!reset_n)
            rd_flags_pri && ev_pri == `CIU_BYTE_ZERO
            |=> flags_pri_reg == `CIU_BYTE_ZERO)
        else $error("primary flags not cleared by read");
endmodule

// file: tb/ciu_host.sv
`timescale 1ns/10ps
// host side of the control port, one access per call
module ciu_host
(
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle bus from time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken once registered
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// file: tb/test_codec_interrupt_unit.sv
`timescale 1ns/10ps
`include "ciu_cfg.svh"
module test_codec_interrupt_unit;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic test_mode_entry = 1'b0;
    logic clock_ratio_change = 1'b0;
    logic [1:0] serial_frame_format = 2'b00;
    logic [1:0] rate_class = 2'b00;
    logic [3:0] adc_pdn = 4'h0;
    logic [4:0] dac_pdn = 5'h00;
    logic [3:0] input_overrange = 4'h0;
    logic [4:0] output_saturation = 5'h00;
    logic irq_pin_o, irq_pin_oe;
    logic [1:0] idle_pin [3] = '{2'b01, 2'b11, 2'b00};
    logic [1:0] act_pin [3] = '{2'b11, 2'b01, 2'b01};
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    always #50 clk_sys = ~clk_sys;

    ciu_host ciu_host_inst (.clk_sys(clk_sys), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    ciu_core ciu_core_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .test_mode_entry(test_mode_entry),
        .serial_frame_format(serial_frame_format),
        .rate_class(rate_class), .clock_ratio_change(clock_ratio_change),
        .adc_pdn(adc_pdn), .dac_pdn(dac_pdn),
        .input_overrange(input_overrange),
        .output_saturation(output_saturation),
        .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));

    task automatic give_verdict;
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s,
        input logic [7:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        ciu_host_inst.wr(a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        ciu_host_inst.rd(a, v);
        chk($sformatf("reg %h", a), v, e);
    endtask
    // pin as {value, enable} once flags have reached it
    task automatic pin(input logic [1:0] e);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("irq pin", {6'h00, irq_pin_o, irq_pin_oe}, {6'h00, e});
    endtask
    // one-cycle event pulses
    task automatic evt(input logic tm, input logic cr, input logic [3:0] ov,
        input logic [4:0] sat);
        @(posedge clk_sys);
        test_mode_entry <= tm;
        clock_ratio_change <= cr;
        input_overrange <= ov;
        output_saturation <= sat;
        @(posedge clk_sys);
        test_mode_entry <= 1'b0;
        clock_ratio_change <= 1'b0;
        input_overrange <= 4'h0;
        output_saturation <= 5'h00;
    endtask

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_count++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        // reset values, unmapped place, writable bits
        rchk(`CIU_OFS_CONFIG, 8'h00);
        rchk(`CIU_OFS_MASK_PRI, 8'h00);
        rchk(`CIU_OFS_MASK_CLIP, 8'h00);
        rchk(8'h23, 8'h00);
        pin(2'b01);
        w(`CIU_OFS_CONFIG, 8'hFF);
        rchk(`CIU_OFS_CONFIG, 8'hE0);
        pin(2'b01);
        w(`CIU_OFS_MASK_PRI, 8'hFF);
        rchk(`CIU_OFS_MASK_PRI, 8'hEF);
        w(`CIU_OFS_MASK_CLIP, 8'hFF);
        rchk(`CIU_OFS_MASK_CLIP, 8'h1F);
        w(`CIU_OFS_FLAGS_PRI, 8'hFF);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h00);
        // automask on: reading a set flag masks it
        w(`CIU_OFS_CONFIG, 8'h00);
        w(`CIU_OFS_MASK_PRI, 8'h00);
        w(`CIU_OFS_MASK_CLIP, 8'h00);
        evt(1'b1, 1'b0, 4'h0, 5'h00);
        pin(2'b11);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h80);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h00);
        rchk(`CIU_OFS_MASK_PRI, 8'h80);
        evt(1'b0, 1'b0, 4'h0, 5'h01);
        rchk(`CIU_OFS_FLAGS_CLIP, 8'h01);
        rchk(`CIU_OFS_MASK_CLIP, 8'h01);
        evt(1'b1, 1'b0, 4'h0, 5'h00);
        pin(2'b01);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h80);
        // automask off: reads leave masks alone
        w(`CIU_OFS_CONFIG, 8'h80);
        w(`CIU_OFS_MASK_PRI, 8'h00);
        w(`CIU_OFS_MASK_CLIP, 8'h00);
        evt(1'b0, 1'b0, 4'hF, 5'h1F);
        pin(2'b11);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h0F);
        rchk(`CIU_OFS_FLAGS_CLIP, 8'h1F);
        rchk(`CIU_OFS_MASK_PRI, 8'h00);
        rchk(`CIU_OFS_MASK_CLIP, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            evt(1'b0, 1'b0, 4'(1 << i), 5'(1 << i));
            rchk(`CIU_OFS_FLAGS_PRI, {4'h0, 4'(1 << i)});
            rchk(`CIU_OFS_FLAGS_CLIP, 8'(1 << i));
        end
        w(`CIU_OFS_MASK_PRI, 8'h0F);
        w(`CIU_OFS_MASK_CLIP, 8'h1F);
        evt(1'b0, 1'b0, 4'hF, 5'h1F);
        pin(2'b01);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h0F);
        rchk(`CIU_OFS_FLAGS_CLIP, 8'h1F);
        // format, rate and ratio changes while powered
        w(`CIU_OFS_MASK_PRI, 8'h00);
        @(posedge clk_sys);
        serial_frame_format <= 2'b01;
        pin(2'b11);
        @(posedge clk_sys);
        rate_class <= 2'b01;
        pin(2'b11);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h40);
        evt(1'b0, 1'b1, 4'h0, 5'h00);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h60);
        w(`CIU_OFS_MASK_PRI, 8'h40);
        @(posedge clk_sys);
        serial_frame_format <= 2'b10;
        pin(2'b01);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h40);
        w(`CIU_OFS_MASK_PRI, 8'h60);
        evt(1'b0, 1'b1, 4'h0, 5'h00);
        pin(2'b01);
        w(`CIU_OFS_MASK_PRI, 8'h40);
        pin(2'b11);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h60);
        // full power down first, then reformat
        @(posedge clk_sys);
        adc_pdn <= 4'hF;
        dac_pdn <= 5'h1F;
        @(posedge clk_sys);
        serial_frame_format <= 2'b11;
        rate_class <= 2'b10;
        pin(2'b01);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h00);
        w(`CIU_OFS_MASK_PRI, 8'h00);
        @(posedge clk_sys);
        dac_pdn <= 5'h0F;
        @(posedge clk_sys);
        serial_frame_format <= 2'b00;
        pin(2'b11);
        rchk(`CIU_OFS_FLAGS_PRI, 8'h40);
        // high, low and open drain pin styles, idle and active
        for (int s = 0; s < 3; s++)
        begin
            w(`CIU_OFS_CONFIG, 8'h80 | 8'(s << 5));
            pin(idle_pin[s]);
            evt(1'b0, 1'b0, 4'h1, 5'h00);
            pin(act_pin[s]);
            rchk(`CIU_OFS_FLAGS_PRI, 8'h01);
        end
        give_verdict();
    end
endmodule
